// *** include/dacr_pkg.sv ***
// Package with the register map, field layout, reset values and serial port constants
package dacr_pkg;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam int ADDR_W = 13;
  localparam logic [12:0] OFF_CHANNEL_INDEX = 13'h005;
  localparam logic [12:0] OFF_POWER_MODE_SELECT = 13'h008;
  localparam logic [12:0] OFF_ENHANCEMENT_CONTROL = 13'h00c;
  localparam logic [12:0] OFF_SERIAL_OUTPUT_CONTROL = 13'h021;
  localparam logic [12:0] OFF_CHANNEL_POWER_RESET = 13'h022;
  localparam logic [12:0] OFF_TRANSFER_STROBE = 13'h0ff;
  localparam logic [12:0] OFF_RESOLUTION_RATE_OVERRIDE = 13'h100;
  localparam logic [12:0] OFF_USER_IO_CONTROL_TWO = 13'h101;
  localparam logic [12:0] OFF_USER_IO_CONTROL_THREE = 13'h102;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0] RST_CHANNEL_INDEX = 8'h33;
  localparam logic [7:0] RST_POWER_MODE_SELECT = 8'h00;
  localparam logic [7:0] RST_ENHANCEMENT_CONTROL = 8'h00;
  localparam logic [7:0] RST_SERIAL_OUTPUT_CONTROL = 8'h32;
  localparam logic [7:0] RST_CHANNEL_POWER_RESET = 8'h00;
  localparam logic [7:0] RST_RESOLUTION_RATE_OVERRIDE = 8'h00;
  localparam logic [7:0] RST_USER_IO_CONTROL_TWO = 8'h00;
  localparam logic [7:0] RST_USER_IO_CONTROL_THREE = 8'h00;

  // ************************************************************
  // Writable bit masks, open bits are zero
  // ************************************************************
  localparam logic [7:0] MASK_CHANNEL_INDEX = 8'h33;
  localparam logic [7:0] MASK_POWER_MODE_SELECT = 8'h03;
  localparam logic [7:0] MASK_ENHANCEMENT_CONTROL = 8'h04;
  localparam logic [7:0] MASK_SERIAL_OUTPUT_CONTROL = 8'hff;
  localparam logic [7:0] MASK_DATA_CHANNEL = 8'h03;
  localparam logic [7:0] MASK_CLOCK_CHANNEL = 8'h02;
  localparam logic [7:0] MASK_RESOLUTION_RATE_OVERRIDE = 8'h77;
  localparam logic [7:0] MASK_USER_IO_CONTROL_TWO = 8'h01;
  localparam logic [7:0] MASK_USER_IO_CONTROL_THREE = 8'h08;

  // ************************************************************
  // Field positions and codes
  // ************************************************************
  localparam int NUM_TARGETS = 4;
  localparam int NUM_DATA_CHANNELS = 2;
  localparam int SEL_CLOCK_LSB = 4;
  localparam int TRANSFER_BIT = 0;
  localparam int CHOP_BIT = 2;
  localparam int CHAN_POWER_DOWN_BIT = 0;
  localparam int CHAN_OUTPUT_RESET_BIT = 1;
  localparam int OVERRIDE_ENABLE_BIT = 6;
  localparam int RESOLUTION_LSB = 4;
  localparam int RATE_LSB = 0;
  localparam int PULLDOWN_DISABLE_BIT = 0;
  localparam int COMMON_MODE_PD_BIT = 3;
  localparam logic [1:0] FULL_RESOLUTION_CODE = 2'h2;
  localparam logic [2:0] FULL_RATE_CODE = 3'h6;
  localparam logic [1:0] PM_NORMAL = 2'h0;
  localparam logic [1:0] PM_POWER_DOWN = 2'h1;
  localparam logic [1:0] PM_STANDBY = 2'h2;
  localparam logic [1:0] PM_DIGITAL_RESET = 2'h3;

  // ************************************************************
  // Serial port framing
  // ************************************************************
  localparam int RW_BIT = 15;
  localparam logic [4:0] INSTR_LAST_BIT = 5'h0f;
  localparam logic [4:0] DATA_LAST_BIT = 5'h07;

  typedef enum logic [1:0] {
    DACR_INSTR,
    DACR_WRITE,
    DACR_READ,
    DACR_DONE
  } dacr_spi_state_t;

endpackage

// *** include/dacr_chan_if.sv ***
// Interface carrying per-target register traffic between the bank and the channel registers
`timescale 1ns/1ps
interface dacr_chan_if;
  logic wr_en;
  logic [7:0] wr_data;
  logic [3:0] sel;
  logic [7:0] value [4];
  logic [7:0] rd_value;

  modport bank (output wr_en, output wr_data, output sel, input value, input rd_value);
  modport chans (input wr_en, input wr_data, input sel, output value, output rd_value);
endinterface

// *** rtl/dacr_chan_regs.sv ***
// Per-target copies of the channel power and output reset register
`timescale 1ns/1ps
module dacr_chan_regs (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  dacr_chan_if.chans chan_bus
);

  // ************************************************************
  // One register per data or clock channel
  // ************************************************************
  genvar t;
  generate
    for (t = 0; t < dacr_pkg::NUM_TARGETS; t++) begin : g_target
      // Clock channels only carry the output reset bit
      localparam logic [7:0] MASK = (t < dacr_pkg::NUM_DATA_CHANNELS) ?
        dacr_pkg::MASK_DATA_CHANNEL : dacr_pkg::MASK_CLOCK_CHANNEL;
      logic [7:0] target_reg;
      always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
          target_reg <= dacr_pkg::RST_CHANNEL_POWER_RESET;
        end else if (chan_bus.wr_en && chan_bus.sel[t]) begin
          target_reg <= chan_bus.wr_data & MASK;
        end
      end
      assign chan_bus.value[t] = target_reg;
    end
  endgenerate

  // ************************************************************
  // Read back the lowest selected target
  // ************************************************************
  always_comb begin
    chan_bus.rd_value = 8'h00;
    for (int i = dacr_pkg::NUM_TARGETS - 1; i >= 0; i--) begin
      if (chan_bus.sel[i]) begin
        chan_bus.rd_value = chan_bus.value[i];
      end
    end
  end

endmodule // dacr_chan_regs

// *** rtl/dacr_top.sv ***
// Control register bank of the dual converter with its serial port
`timescale 1ns/1ps
// Operation
// - Every register write takes effect at once, except the resolution/rate override.
// - Override settings take effect only when transfer bit 0 is written high.
// - Channel index bits 1:0 choose which data channel takes per-channel writes.
// - Global registers apply to all channels regardless of channel index.
// - Channel index can also select clock channels for a reduced per-channel set.
// - Power mode 00 keeps both channels and datapaths running.
// - Power mode 01 stops datapath clocks, resets datapath, disables outputs.
// - Power mode 10 stops datapath clocks and disables outputs without reset.
// - Power mode 11 resets datapath clocking and outputs, not the serial port.
// - Serial port is reset only by power-on reset, never by registers.
// - Enhancement bit 2 enables chopping in the first converter stage.
// - Override rate field limits maximum rate capability, not the actual rate.
// - User I/O two bit 0 disables the serial data pin pull-down.
// - User I/O three bit 3 powers down the common-mode generator.
module dacr_top (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic spi_clk_in,
  input wire logic spi_cs_n_in,
  input wire logic spi_dio_in,
  output logic spi_dio_out,
  output logic spi_dio_oe_out,
  output logic chop_enable_out,
  output logic datapath_clk_en_out,
  output logic datapath_reset_out,
  output logic clock_gen_reset_out,
  output logic outputs_enable_out,
  output logic outputs_reset_out,
  output logic [1:0] chan_power_down_out,
  output logic [3:0] chan_output_reset_out,
  output logic [7:0] serial_output_mode_out,
  output logic override_enable_out,
  output logic [1:0] resolution_code_out,
  output logic [2:0] rate_limit_code_out,
  output logic sdio_pulldown_disable_out,
  output logic common_mode_generator_pd_out
);

  // ************************************************************
  // Serial port edge detection
  // ************************************************************
  // Pins are synchronous to ref_clk_in, so a one-cycle delay is enough
  logic sclk_q;
  dacr_pkg::dacr_spi_state_t spi_state;
  logic [4:0] bit_cnt;
  logic [15:0] shift_in;
  logic [12:0] reg_addr;
  logic [7:0] tx_shift;

  wire sclk_rise = spi_clk_in & ~sclk_q & ~spi_cs_n_in;
  wire sclk_fall = ~spi_clk_in & sclk_q & ~spi_cs_n_in;
  wire [15:0] next_shift = {shift_in[14:0], spi_dio_in};
  wire instr_done = (spi_state == dacr_pkg::DACR_INSTR) && sclk_rise && (bit_cnt == dacr_pkg::INSTR_LAST_BIT);
  wire data_last = sclk_rise && (bit_cnt == dacr_pkg::DATA_LAST_BIT);
  wire wr_strobe = (spi_state == dacr_pkg::DACR_WRITE) && data_last;
  wire [7:0] wr_data = next_shift[7:0];
  wire [12:0] rd_addr = (spi_state == dacr_pkg::DACR_INSTR) ? next_shift[12:0] : reg_addr;

  // ************************************************************
  // Serial port sequencer
  // ************************************************************
  // Only reset_in touches this logic; power modes never reach it
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      sclk_q <= 1'b0;
      spi_state <= dacr_pkg::DACR_INSTR;
      bit_cnt <= 5'h00;
    end else begin
      sclk_q <= spi_clk_in;
      if (spi_cs_n_in) begin
        spi_state <= dacr_pkg::DACR_INSTR;
        bit_cnt <= 5'h00;
      end else begin
        unique case (spi_state)
          dacr_pkg::DACR_INSTR: begin
            if (instr_done) begin
              spi_state <= next_shift[dacr_pkg::RW_BIT] ? dacr_pkg::DACR_READ : dacr_pkg::DACR_WRITE;
              bit_cnt <= 5'h00;
            end else if (sclk_rise) begin
              bit_cnt <= bit_cnt + 5'h01;
            end
          end
          dacr_pkg::DACR_WRITE, dacr_pkg::DACR_READ: begin
            if (data_last) begin
              spi_state <= dacr_pkg::DACR_DONE;
            end else if (sclk_rise) begin
              bit_cnt <= bit_cnt + 5'h01;
            end
          end
          // Bits past the data byte are ignored until chip select rises
          dacr_pkg::DACR_DONE: begin
            bit_cnt <= bit_cnt;
          end
        endcase
      end
    end
  end

  // ************************************************************
  // Serial shift registers
  // ************************************************************
  logic [7:0] rd_data;

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      shift_in <= 16'h0000;
      reg_addr <= 13'h0000;
    end else if (sclk_rise) begin
      shift_in <= next_shift;
      // Address frozen with the instruction for decode and read-back
      if (instr_done) begin
        reg_addr <= next_shift[12:0];
      end
    end
  end

  // Read data is captured with the instruction, so a late write cannot tear it
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      tx_shift <= 8'h00;
      spi_dio_out <= 1'b0;
    end else if (instr_done) begin
      tx_shift <= rd_data;
    end else if (sclk_fall && spi_state == dacr_pkg::DACR_READ) begin
      spi_dio_out <= tx_shift[7];
      tx_shift <= {tx_shift[6:0], 1'b0};
    end
  end

  assign spi_dio_oe_out = (spi_state == dacr_pkg::DACR_READ) && ~spi_cs_n_in;

  // ************************************************************
  // Register bank
  // ************************************************************
  logic [7:0] channel_index;
  logic [7:0] power_mode_select;
  logic [7:0] enhancement_control;
  logic [7:0] serial_output_control;
  logic [7:0] override_pending;
  logic [7:0] override_active;
  logic [7:0] user_io_control_two;
  logic [7:0] user_io_control_three;

  // ************************************************************
  // Write decode
  // ************************************************************
  // One strobe per register, raised on the last data bit
  wire hit_index = wr_strobe && (reg_addr == dacr_pkg::OFF_CHANNEL_INDEX);
  wire hit_power = wr_strobe && (reg_addr == dacr_pkg::OFF_POWER_MODE_SELECT);
  wire hit_enh = wr_strobe && (reg_addr == dacr_pkg::OFF_ENHANCEMENT_CONTROL);
  wire hit_serial = wr_strobe && (reg_addr == dacr_pkg::OFF_SERIAL_OUTPUT_CONTROL);
  wire hit_chan = wr_strobe && (reg_addr == dacr_pkg::OFF_CHANNEL_POWER_RESET);
  wire hit_xfer = wr_strobe && (reg_addr == dacr_pkg::OFF_TRANSFER_STROBE);
  wire hit_override = wr_strobe && (reg_addr == dacr_pkg::OFF_RESOLUTION_RATE_OVERRIDE);
  wire hit_uio2 = wr_strobe && (reg_addr == dacr_pkg::OFF_USER_IO_CONTROL_TWO);
  wire hit_uio3 = wr_strobe && (reg_addr == dacr_pkg::OFF_USER_IO_CONTROL_THREE);
  // Transfer bit 0 is one-shot; the other transfer bits do nothing
  wire xfer_load = hit_xfer && wr_data[dacr_pkg::TRANSFER_BIT];

  // ************************************************************
  // Masked write data
  // ************************************************************
  // Open bits are cut here, so they can never be stored
  wire [7:0] next_channel_index = wr_data & dacr_pkg::MASK_CHANNEL_INDEX;
  wire [7:0] next_power_mode = wr_data & dacr_pkg::MASK_POWER_MODE_SELECT;
  wire [7:0] next_enhancement = wr_data & dacr_pkg::MASK_ENHANCEMENT_CONTROL;
  wire [7:0] next_serial_output = wr_data & dacr_pkg::MASK_SERIAL_OUTPUT_CONTROL;
  wire [7:0] next_override = wr_data & dacr_pkg::MASK_RESOLUTION_RATE_OVERRIDE;
  wire [7:0] next_user_io_two = wr_data & dacr_pkg::MASK_USER_IO_CONTROL_TWO;
  wire [7:0] next_user_io_three = wr_data & dacr_pkg::MASK_USER_IO_CONTROL_THREE;

  // Global registers ignore the channel index
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      channel_index <= dacr_pkg::RST_CHANNEL_INDEX;
      power_mode_select <= dacr_pkg::RST_POWER_MODE_SELECT;
      enhancement_control <= dacr_pkg::RST_ENHANCEMENT_CONTROL;
      serial_output_control <= dacr_pkg::RST_SERIAL_OUTPUT_CONTROL;
    end else begin
      if (hit_index) channel_index <= next_channel_index;
      if (hit_power) power_mode_select <= next_power_mode;
      if (hit_enh) enhancement_control <= next_enhancement;
      if (hit_serial) serial_output_control <= next_serial_output;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      override_pending <= dacr_pkg::RST_RESOLUTION_RATE_OVERRIDE;
      override_active <= dacr_pkg::RST_RESOLUTION_RATE_OVERRIDE;
      user_io_control_two <= dacr_pkg::RST_USER_IO_CONTROL_TWO;
      user_io_control_three <= dacr_pkg::RST_USER_IO_CONTROL_THREE;
    end else begin
      if (hit_override) override_pending <= next_override;
      if (xfer_load) override_active <= override_pending;
      if (hit_uio2) user_io_control_two <= next_user_io_two;
      if (hit_uio3) user_io_control_three <= next_user_io_three;
    end
  end

  // ************************************************************
  // Per-channel registers
  // ************************************************************
  dacr_chan_if chan_bus ();

  assign chan_bus.wr_en = hit_chan;
  assign chan_bus.wr_data = wr_data;
  assign chan_bus.sel = {channel_index[dacr_pkg::SEL_CLOCK_LSB +: 2], channel_index[1:0]};

  dacr_chan_regs u_chan_regs (
    .ref_clk_in (ref_clk_in),
    .reset_in (reset_in),
    .chan_bus (chan_bus)
  );

  // ************************************************************
  // Read decode
  // ************************************************************
  // Transfer reads zero, it acts as a strobe; unmapped addresses read zero
  always_comb begin
    unique case (rd_addr)
      dacr_pkg::OFF_CHANNEL_INDEX: rd_data = channel_index;
      dacr_pkg::OFF_POWER_MODE_SELECT: rd_data = power_mode_select;
      dacr_pkg::OFF_ENHANCEMENT_CONTROL: rd_data = enhancement_control;
      dacr_pkg::OFF_SERIAL_OUTPUT_CONTROL: rd_data = serial_output_control;
      dacr_pkg::OFF_CHANNEL_POWER_RESET: rd_data = chan_bus.rd_value;
      dacr_pkg::OFF_RESOLUTION_RATE_OVERRIDE: rd_data = override_pending;
      dacr_pkg::OFF_USER_IO_CONTROL_TWO: rd_data = user_io_control_two;
      dacr_pkg::OFF_USER_IO_CONTROL_THREE: rd_data = user_io_control_three;
      default: rd_data = 8'h00;
    endcase
  end

  // ************************************************************
  // Power mode and control outputs
  // ************************************************************
  wire [1:0] pm = power_mode_select[1:0];
  wire next_clk_en = (pm == dacr_pkg::PM_NORMAL);
  wire next_dp_reset = (pm == dacr_pkg::PM_POWER_DOWN) || (pm == dacr_pkg::PM_DIGITAL_RESET);
  wire next_clkgen_reset = (pm == dacr_pkg::PM_DIGITAL_RESET);
  wire next_out_en = (pm == dacr_pkg::PM_NORMAL) || (pm == dacr_pkg::PM_DIGITAL_RESET);
  wire next_out_reset = (pm == dacr_pkg::PM_DIGITAL_RESET);
  wire next_override_en = override_active[dacr_pkg::OVERRIDE_ENABLE_BIT];
  // Rate code is a capability ceiling only; sampling itself is untouched
  wire [2:0] next_rate = next_override_en ? override_active[dacr_pkg::RATE_LSB +: 3] : dacr_pkg::FULL_RATE_CODE;
  wire [1:0] next_res = next_override_en ?
    override_active[dacr_pkg::RESOLUTION_LSB +: 2] : dacr_pkg::FULL_RESOLUTION_CODE;
  logic [1:0] next_chan_pd;
  logic [3:0] next_chan_rst;
  // Registered so a mode change never glitches the datapath controls
  wire next_chop = enhancement_control[dacr_pkg::CHOP_BIT];
  wire next_pulldown_dis = user_io_control_two[dacr_pkg::PULLDOWN_DISABLE_BIT];
  wire next_common_mode_pd = user_io_control_three[dacr_pkg::COMMON_MODE_PD_BIT];

  genvar c;
  generate
    for (c = 0; c < dacr_pkg::NUM_TARGETS; c++) begin : g_chan_out
      if (c < dacr_pkg::NUM_DATA_CHANNELS) begin : g_pd
        assign next_chan_pd[c] = chan_bus.value[c][dacr_pkg::CHAN_POWER_DOWN_BIT];
      end
      assign next_chan_rst[c] = chan_bus.value[c][dacr_pkg::CHAN_OUTPUT_RESET_BIT];
    end
  endgenerate

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      datapath_clk_en_out <= 1'b1;
      datapath_reset_out <= 1'b0;
      clock_gen_reset_out <= 1'b0;
      outputs_enable_out <= 1'b1;
      outputs_reset_out <= 1'b0;
      chop_enable_out <= 1'b0;
      chan_power_down_out <= 2'h0;
      chan_output_reset_out <= 4'h0;
      serial_output_mode_out <= dacr_pkg::RST_SERIAL_OUTPUT_CONTROL;
      override_enable_out <= 1'b0;
      resolution_code_out <= dacr_pkg::FULL_RESOLUTION_CODE;
      rate_limit_code_out <= dacr_pkg::FULL_RATE_CODE;
      sdio_pulldown_disable_out <= 1'b0;
      common_mode_generator_pd_out <= 1'b0;
    end else begin
      datapath_clk_en_out <= next_clk_en;
      datapath_reset_out <= next_dp_reset;
      clock_gen_reset_out <= next_clkgen_reset;
      outputs_enable_out <= next_out_en;
      outputs_reset_out <= next_out_reset;
      chop_enable_out <= next_chop;
      chan_power_down_out <= next_chan_pd;
      chan_output_reset_out <= next_chan_rst;
      serial_output_mode_out <= serial_output_control;
      override_enable_out <= next_override_en;
      resolution_code_out <= next_res;
      rate_limit_code_out <= next_rate;
      sdio_pulldown_disable_out <= next_pulldown_dis;
      common_mode_generator_pd_out <= next_common_mode_pd;
    end
  end

endmodule // dacr_top

// *** bench/dacr_host_model.sv ***
// Host controller model driving the serial port
`timescale 1ns/1ps
module dacr_host_model (
  input wire logic ref_clk_in,
  input wire logic dio_in,
  input wire logic dio_oe_in,
  input wire logic pd_dis_in,
  output logic sclk_out,
  output logic cs_n_out,
  output logic dio_out
);
  logic drv;
  logic bit_v;
  logic last;
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    drv = 1'b0;
    bit_v = 1'b0;
    last = 1'b0;
  end
  // Released line: pull-down, or a toggling level once it is disabled
  assign dio_out = dio_oe_in ? dio_in : drv ? bit_v : pd_dis_in ? ~last : 1'b0;
  always @(posedge ref_clk_in) last <= dio_out;
  task automatic wait_n(input int n);
    repeat (n) @(negedge ref_clk_in);
  endtask
  // Each serial clock phase lasts three reference cycles
  task automatic xfer(input logic rd, input logic [12:0] a, input logic [7:0] wd, output logic [7:0] rdat);
    logic [23:0] sh;
    sh = {rd, 2'h0, a, wd};
    rdat = 8'h00;
    @(negedge ref_clk_in);
    cs_n_out = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      sclk_out = 1'b0;
      drv = !(rd && i < 8);
      bit_v = sh[i];
      wait_n(3);
      if (!drv) rdat[i] = dio_out;
      sclk_out = 1'b1;
      wait_n(3);
    end
    sclk_out = 1'b0;
    drv = 1'b0;
    wait_n(1);
    cs_n_out = 1'b1;
    wait_n(2);
  endtask
  task automatic strobe();
    logic [7:0] d;
    xfer(1'b0, dacr_pkg::OFF_TRANSFER_STROBE, 8'h01, d);
  endtask
endmodule // dacr_host_model

// *** bench/dacr_top_assertions.sv ***
// Checker of the register bank outputs
`timescale 1ns/1ps
module dacr_top_assertions (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic spi_clk_in,
  input wire logic spi_cs_n_in,
  input wire logic spi_dio_oe_out,
  input wire logic chop_enable_out,
  input wire logic datapath_clk_en_out,
  input wire logic datapath_reset_out,
  input wire logic clock_gen_reset_out,
  input wire logic outputs_enable_out,
  input wire logic outputs_reset_out,
  input wire logic override_enable_out,
  input wire logic [1:0] resolution_code_out,
  input wire logic [2:0] rate_limit_code_out,
  input wire logic [7:0] serial_output_mode_out
);
  // ********
  // Properties
  // ********
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  sequence s_cs_idle;
    spi_cs_n_in [*2];
  endsequence
  sequence s_bit_taken;
    !spi_cs_n_in && spi_clk_in;
  endsequence
  AST_NORMAL: assert property (datapath_clk_en_out |->
    !datapath_reset_out && outputs_enable_out && !outputs_reset_out)
    else $error("clocks run while datapath held");
  AST_PWR_DOWN: assert property (datapath_reset_out && !clock_gen_reset_out |->
    !datapath_clk_en_out && !outputs_enable_out)
    else $error("power down leaves clocks or outputs on");
  AST_STANDBY: assert property (!datapath_clk_en_out && !datapath_reset_out |->
    !outputs_enable_out && !outputs_reset_out)
    else $error("standby leaves outputs on or reset");
  AST_DIG_RESET: assert property (clock_gen_reset_out |->
    datapath_reset_out && outputs_reset_out && !datapath_clk_en_out)
    else $error("digital reset incomplete");
  AST_IDLE_STABLE: assert property (s_cs_idle |->
    $stable({chop_enable_out, datapath_clk_en_out, serial_output_mode_out,
    override_enable_out, resolution_code_out, rate_limit_code_out}))
    else $error("setting changed without a frame");
  AST_OE_CS: assert property (spi_cs_n_in |-> !spi_dio_oe_out)
    else $error("data driven while deselected");
  AST_OE_RISE: assert property ($rose(spi_dio_oe_out) |-> $past(!spi_cs_n_in && spi_clk_in))
    else $error("read drive not after a taken bit");
  AST_NO_OVR: assert property (!override_enable_out |->
    resolution_code_out == 2'h2 && rate_limit_code_out == 3'h6)
    else $error("limits active without override");
  COV_READ: cover property (s_bit_taken ##1 $rose(spi_dio_oe_out));
endmodule // dacr_top_assertions
bind dacr_top dacr_top_assertions chk_u (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .spi_clk_in(spi_clk_in),
  .spi_cs_n_in(spi_cs_n_in), .spi_dio_oe_out(spi_dio_oe_out), .chop_enable_out(chop_enable_out),
  .datapath_clk_en_out(datapath_clk_en_out), .datapath_reset_out(datapath_reset_out),
  .clock_gen_reset_out(clock_gen_reset_out), .outputs_enable_out(outputs_enable_out),
  .outputs_reset_out(outputs_reset_out), .override_enable_out(override_enable_out),
  .resolution_code_out(resolution_code_out), .rate_limit_code_out(rate_limit_code_out),
  .serial_output_mode_out(serial_output_mode_out));

// *** bench/test_dual_adc_control_registers.sv ***
// Self-checking bench of the dual converter register bank
`timescale 1ns/1ps
module test_dual_adc_control_registers;
  logic ref_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic sclk, cs_n, dio_w, dio_o, dio_oe, cen, drst, cgrst, oen, orst, chop, ovr, pdd, cmpd;
  logic [1:0] cpd, res;
  logic [3:0] cor;
  logic [2:0] rate;
  logic [7:0] som, rd, v;
  logic [7:0] vv [6];
  int err_total = 0;
  int checks = 0;
  int cyc = 0;
  logic [12:0] ra [10] = '{13'h005, 13'h008, 13'h00c, 13'h021, 13'h022, 13'h100, 13'h101, 13'h102, 13'h0ff, 13'h1ff};
  logic [7:0] rv [10] = '{8'h33, 8'h00, 8'h00, 8'h32, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [12:0] ga [6] = '{13'h008, 13'h00c, 13'h021, 13'h101, 13'h102, 13'h005};
  logic [7:0] gm [6] = '{8'h03, 8'h04, 8'hff, 8'h01, 8'h08, 8'h33};
  always #4 ref_clk_in = ~ref_clk_in;
  dacr_host_model host_u (.ref_clk_in(ref_clk_in), .dio_in(dio_o), .dio_oe_in(dio_oe), .pd_dis_in(pdd),
    .sclk_out(sclk), .cs_n_out(cs_n), .dio_out(dio_w));
  dacr_top dut_u (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .spi_clk_in(sclk), .spi_cs_n_in(cs_n),
    .spi_dio_in(dio_w), .spi_dio_out(dio_o), .spi_dio_oe_out(dio_oe), .chop_enable_out(chop),
    .datapath_clk_en_out(cen), .datapath_reset_out(drst), .clock_gen_reset_out(cgrst),
    .outputs_enable_out(oen), .outputs_reset_out(orst), .chan_power_down_out(cpd),
    .chan_output_reset_out(cor), .serial_output_mode_out(som), .override_enable_out(ovr),
    .resolution_code_out(res), .rate_limit_code_out(rate), .sdio_pulldown_disable_out(pdd),
    .common_mode_generator_pd_out(cmpd));
  // Clock enable, datapath reset, clock reset, output enable, output reset
  function automatic logic [4:0] pm_exp(input logic [1:0] m);
    case (m)
      2'h0: return 5'h12;
      2'h1: return 5'h08;
      2'h2: return 5'h00;
      default: return 5'h0f;
    endcase
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    if (err_total == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    host_u.xfer(1'b0, a, d, rd);
  endtask
  task automatic rdc(input logic [12:0] a, input logic [7:0] e);
    host_u.xfer(1'b1, a, 8'h00, rd);
    chk(rd, e);
  endtask
  // Whole run needs about 12000 cycles
  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      test_done();
    end
  end
  initial begin
    void'($urandom(32'h539af70e));
    repeat (2) @(negedge ref_clk_in);
    reset_in = 1'b0;
    chk({cen, drst, cgrst, oen, orst, res, rate, som}, {5'h12, 2'h2, 3'h6, 8'h32});
    for (int i = 0; i < 10; i++) rdc(ra[i], rv[i]);
    // ********
    // Global registers, random data
    // ********
    for (int r = 0; r < 3; r++) begin
      for (int i = 0; i < 6; i++) begin
        vv[i] = 8'($urandom);
        wr(ga[i], vv[i]);
        rdc(ga[i], vv[i] & gm[i]);
      end
      chk({chop, som, pdd, cmpd}, {vv[1][2], vv[2], vv[3][0], vv[4][3]});
      chk({cen, drst, cgrst, oen, orst}, pm_exp(vv[0][1:0]));
      wr(13'h1ff, 8'($urandom));
      rdc(13'h1ff, 8'h00);
    end
    // Serial port must answer in every power mode
    for (int m = 0; m < 4; m++) begin
      wr(dacr_pkg::OFF_POWER_MODE_SELECT, 8'(m));
      chk({cen, drst, cgrst, oen, orst}, pm_exp(2'(m)));
      rdc(dacr_pkg::OFF_POWER_MODE_SELECT, 8'(m));
    end
    wr(dacr_pkg::OFF_POWER_MODE_SELECT, 8'h00);
    // ********
    // Deferred override
    // ********
    v = 8'($urandom);
    v[6] = 1'b1;
    wr(dacr_pkg::OFF_RESOLUTION_RATE_OVERRIDE, v);
    chk({ovr, res, rate}, {1'b0, 2'h2, 3'h6});
    rdc(dacr_pkg::OFF_RESOLUTION_RATE_OVERRIDE, v & 8'h77);
    host_u.strobe();
    chk({ovr, res, rate}, {1'b1, v[5:4], v[2:0]});
    rdc(dacr_pkg::OFF_TRANSFER_STROBE, 8'h00);
    wr(dacr_pkg::OFF_RESOLUTION_RATE_OVERRIDE, 8'h00);
    chk({ovr, res, rate}, {1'b1, v[5:4], v[2:0]});
    host_u.strobe();
    chk({ovr, res, rate}, {1'b0, 2'h2, 3'h6});
    // ********
    // Channel selection
    // ********
    wr(13'h005, 8'h01);
    wr(13'h022, 8'h03);
    chk({cpd, cor}, {2'h1, 4'h1});
    wr(13'h005, 8'h02);
    wr(13'h022, 8'h02);
    chk({cpd, cor}, {2'h1, 4'h3});
    wr(13'h005, 8'h10);
    wr(13'h022, 8'h03);
    chk({cpd, cor}, {2'h1, 4'h7});
    rdc(13'h022, 8'h02);
    wr(13'h00c, 8'h04);
    chk(chop, 1'b1);
    wr(13'h005, 8'h00);
    rdc(13'h022, 8'h00);
    wr(13'h00c, 8'h00);
    chk(chop, 1'b0);
    test_done();
  end
endmodule // test_dual_adc_control_registers
